// [lbr_pkg.sv]
// constants for the led brightness and ramp controller
// assumes a single 20 MHz core clock and a two-wire serial register port
package lbr_pkg;

  // core clock
  localparam int CLK_MHZ = 20;
  localparam int CLK_KHZ = 20000;

  // ramp dwell times, as printed, per step code
  localparam int STEP_FAST_US = 100;
  localparam int STEP_MID_MS = 25;
  localparam int STEP_SLOW_MS = 50;
  localparam int STEP_SLOWEST_MS = 100;

  // dwell counts in core clock cycles
  localparam int STEP_FAST_CYC = STEP_FAST_US * CLK_MHZ;
  localparam int STEP_MID_CYC = STEP_MID_MS * CLK_KHZ;
  localparam int STEP_SLOW_CYC = STEP_SLOW_MS * CLK_KHZ;
  localparam int STEP_SLOWEST_CYC = STEP_SLOWEST_MS * CLK_KHZ;
  localparam int DWELL_W = 21;

  // ramp step codes
  localparam logic [1:0] RAMP_CODE_FAST = 2'h0;
  localparam logic [1:0] RAMP_CODE_MID = 2'h1;
  localparam logic [1:0] RAMP_CODE_SLOW = 2'h2;

  // serial port device address (7 bits)
  localparam logic [6:0] DEV_ADDR = 7'h36;

  // register offsets
  localparam logic [7:0] GEN_PURPOSE_ADDR = 8'h10;
  localparam logic [7:0] RAMP_STEP_TIME_ADDR = 8'h20;
  localparam logic [7:0] PRIMARY_GROUP_BRIGHTNESS_ADDR = 8'hA0;
  localparam logic [7:0] SECONDARY_GROUP_BRIGHTNESS_ADDR = 8'hB0;
  localparam logic [7:0] INDICATOR_BRIGHTNESS_ADDR = 8'hC0;

  // values after reset, and the read value of unmapped offsets
  localparam logic [7:0] GEN_PURPOSE_RST = 8'h00;
  localparam logic [7:0] PRIMARY_GROUP_BRIGHTNESS_RST = 8'hE0;
  localparam logic [7:0] SECONDARY_GROUP_BRIGHTNESS_RST = 8'hF8;
  localparam logic [7:0] INDICATOR_BRIGHTNESS_RST = 8'hF8;
  localparam logic [7:0] RAMP_STEP_TIME_RST = 8'hF0;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // general purpose register field positions
  localparam int GP_PRIMARY_ON = 0;
  localparam int GP_SECONDARY_ON = 1;
  localparam int GP_INDICATOR_ON = 2;
  localparam int GP_FIRST_TO_PRIMARY = 3;
  localparam int GP_SECOND_TO_PRIMARY = 4;
  localparam int GP_SHUT_FIVE_THREE = 5;
  localparam int GP_SHUT_SIX_TWO = 6;

  // level and ramp step code field widths
  localparam int PRIMARY_LVL_W = 5;
  localparam int AUX_LVL_W = 3;
  localparam int RAMP_CODE_W = 2;

  // serial engine states
  typedef enum logic [4:0] {
    LBR_IDLE = 5'b00001,
    LBR_DEV = 5'b00010,
    LBR_PTR = 5'b00100,
    LBR_WR = 5'b01000,
    LBR_RD = 5'b10000
  } lbr_state_t;

endpackage : lbr_pkg

// [lbr_ramp.sv]
// primary group ramp engine: walks the applied level one code at a time
// assumes the enable, target and step code come from registers on core_clk
`timescale 1ns/1ps

module lbr_ramp #(
  parameter logic [20:0] FAST_CYC = 21'(lbr_pkg::STEP_FAST_CYC),
  parameter logic [20:0] MID_CYC = 21'(lbr_pkg::STEP_MID_CYC),
  parameter logic [20:0] SLOW_CYC = 21'(lbr_pkg::STEP_SLOW_CYC),
  parameter logic [20:0] SLOWEST_CYC = 21'(lbr_pkg::STEP_SLOWEST_CYC)
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // settings
  input wire logic group_on,
  input wire logic [4:0] target,
  input wire logic [1:0] step_code,
  // applied level
  output logic [4:0] level,
  output logic sinks_on
);

  logic [20:0] dwell_cnt;
  logic [20:0] next_dwell_cnt;
  logic [4:0] next_level;

  // disabled means the ramp heads for code zero, then the sinks go dark
  wire [4:0] goal = group_on ? target : 5'h00;
  wire at_goal = (level == goal);
  wire [20:0] dwell_len =
    (step_code == lbr_pkg::RAMP_CODE_FAST) ? FAST_CYC :
    (step_code == lbr_pkg::RAMP_CODE_MID) ? MID_CYC :
    (step_code == lbr_pkg::RAMP_CODE_SLOW) ? SLOW_CYC : SLOWEST_CYC;
  wire dwell_done = (dwell_cnt == dwell_len - 21'h000001);
  wire going_up = (level < goal);

  // one code per elapsed dwell, so total time is target times dwell
  always_comb begin
    next_dwell_cnt = dwell_cnt;
    next_level = level;
    if (at_goal) begin
      next_dwell_cnt = 21'h000000;
    end else if (dwell_done) begin
      next_dwell_cnt = 21'h000000;
      next_level = going_up ? level + 5'h01 : level - 5'h01;
    end else begin
      next_dwell_cnt = dwell_cnt + 21'h000001;
    end
  end

  // sinks stay lit while enabled or still winding down
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dwell_cnt <= 21'h000000;
      level <= 5'h00;
      sinks_on <= 1'b0;
    end else begin
      dwell_cnt <= next_dwell_cnt;
      level <= next_level;
      sinks_on <= group_on || (next_level != 5'h00);
    end
  end

endmodule : lbr_ramp

// [lbr_ctrl.sv]
// led brightness controller: two-wire serial register slave, group gating
// assumes scl and sda arrive from pins asynchronous to core_clk; sda is open drain
`timescale 1ns/1ps

module lbr_ctrl #(
  parameter logic [20:0] STEP_MID_CYC = 21'(lbr_pkg::STEP_MID_CYC),
  parameter logic [20:0] STEP_SLOW_CYC = 21'(lbr_pkg::STEP_SLOW_CYC),
  parameter logic [20:0] STEP_SLOWEST_CYC = 21'(lbr_pkg::STEP_SLOWEST_CYC)
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // serial register port
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // primary group sinks
  output logic [4:0] primary_sinks_level,
  output logic primary_sinks_on,
  // secondary group sinks
  output logic [2:0] secondary_sinks_level,
  output logic secondary_sinks_on,
  // indicator sink
  output logic [2:0] indicator_sink_level,
  output logic indicator_sink_on,
  // reassignable sinks
  output logic flex_sink_first_on,
  output logic flex_sink_first_in_primary,
  output logic flex_sink_second_on,
  output logic flex_sink_second_in_primary
);

  // pin synchronisers; stage one feeds only stage two
  logic scl_s1;
  logic scl_s2;
  logic scl_s3;
  logic sda_s1;
  logic sda_s2;
  logic sda_s3;

  // serial engine
  lbr_pkg::lbr_state_t st;
  logic [3:0] bit_cnt;
  logic [7:0] shift;
  logic [7:0] rd_shift;
  logic in_ack;
  logic rw_read;
  logic [7:0] ptr;

  // register file
  logic [6:0] gen_purpose;
  logic [4:0] primary_group_brightness;
  logic [2:0] secondary_group_brightness;
  logic [2:0] indicator_brightness;
  logic [1:0] ramp_step_time;

  // ramp engine outputs
  logic [4:0] ramp_level;
  logic ramp_sinks_on;

  // two flops on each pin before any logic looks at it
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_s3 <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_s3 <= 1'b1;
    end else begin
      scl_s1 <= scl;
      scl_s2 <= scl_s1;
      scl_s3 <= scl_s2;
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
      sda_s3 <= sda_s2;
    end
  end

  // bus events, all from the second and third stages
  wire scl_rise = scl_s2 && !scl_s3;
  wire scl_fall = !scl_s2 && scl_s3;
  wire bus_start = scl_s2 && scl_s3 && !sda_s2 && sda_s3;
  wire bus_stop = scl_s2 && scl_s3 && sda_s2 && !sda_s3;
  wire byte_done = scl_fall && !in_ack && (bit_cnt == 4'h8);
  wire ack_done = scl_fall && in_ack;
  wire addr_hit = (shift[7:1] == lbr_pkg::DEV_ADDR);

  // a data byte lands in the register file on the fall that ends it
  wire wr_fire = byte_done && (st == lbr_pkg::LBR_WR);

  // register decode
  wire sel_gp = (ptr == lbr_pkg::GEN_PURPOSE_ADDR);
  wire sel_ramp = (ptr == lbr_pkg::RAMP_STEP_TIME_ADDR);
  wire sel_pri = (ptr == lbr_pkg::PRIMARY_GROUP_BRIGHTNESS_ADDR);
  wire sel_sec = (ptr == lbr_pkg::SECONDARY_GROUP_BRIGHTNESS_ADDR);
  wire sel_ind = (ptr == lbr_pkg::INDICATOR_BRIGHTNESS_ADDR);

  // read-back: unused upper bits return their reset pattern
  wire [7:0] rd_value =
    sel_gp ? {lbr_pkg::GEN_PURPOSE_RST[7], gen_purpose} :
    sel_ramp ? {lbr_pkg::RAMP_STEP_TIME_RST[7:2], ramp_step_time} :
    sel_pri ? {lbr_pkg::PRIMARY_GROUP_BRIGHTNESS_RST[7:5], primary_group_brightness} :
    sel_sec ? {lbr_pkg::SECONDARY_GROUP_BRIGHTNESS_RST[7:3], secondary_group_brightness} :
    sel_ind ? {lbr_pkg::INDICATOR_BRIGHTNESS_RST[7:3], indicator_brightness} :
    lbr_pkg::UNMAPPED_READ;

  // slave state machine; start and stop win over any bit activity
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st <= lbr_pkg::LBR_IDLE;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      rd_shift <= 8'h00;
      in_ack <= 1'b0;
      rw_read <= 1'b0;
      ptr <= 8'h00;
      sda_oe <= 1'b0;
    end else if (bus_start) begin
      st <= lbr_pkg::LBR_DEV;
      bit_cnt <= 4'h0;
      in_ack <= 1'b0;
      sda_oe <= 1'b0;
    end else if (bus_stop) begin
      st <= lbr_pkg::LBR_IDLE;
      in_ack <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      case (st)
        lbr_pkg::LBR_IDLE: begin
          sda_oe <= 1'b0;
        end
        lbr_pkg::LBR_DEV: begin
          if (scl_rise && !in_ack) begin
            shift <= {shift[6:0], sda_s2};
            bit_cnt <= bit_cnt + 4'h1;
          end
          if (byte_done) begin
            // a foreign address leaves the bus alone until the next start
            if (addr_hit) begin
              in_ack <= 1'b1;
              sda_oe <= 1'b1;
              rw_read <= shift[0];
            end else begin
              st <= lbr_pkg::LBR_IDLE;
            end
          end else if (ack_done) begin
            in_ack <= 1'b0;
            bit_cnt <= 4'h0;
            if (rw_read) begin
              // first data bit goes out on the fall that ends the ack
              st <= lbr_pkg::LBR_RD;
              sda_oe <= !rd_value[7];
              rd_shift <= {rd_value[6:0], 1'b1};
              bit_cnt <= 4'h1;
            end else begin
              st <= lbr_pkg::LBR_PTR;
              sda_oe <= 1'b0;
            end
          end
        end
        lbr_pkg::LBR_PTR, lbr_pkg::LBR_WR: begin
          if (scl_rise && !in_ack) begin
            shift <= {shift[6:0], sda_s2};
            bit_cnt <= bit_cnt + 4'h1;
          end
          if (byte_done) begin
            in_ack <= 1'b1;
            sda_oe <= 1'b1;
            if (st == lbr_pkg::LBR_PTR) begin
              ptr <= shift;
            end
          end else if (ack_done) begin
            // pointer does not advance; further bytes rewrite one register
            in_ack <= 1'b0;
            bit_cnt <= 4'h0;
            sda_oe <= 1'b0;
            st <= lbr_pkg::LBR_WR;
          end
        end
        lbr_pkg::LBR_RD: begin
          if (scl_fall && !in_ack && bit_cnt != 4'h8) begin
            sda_oe <= !rd_shift[7];
            rd_shift <= {rd_shift[6:0], 1'b1};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (byte_done) begin
            // release for the host's acknowledge
            sda_oe <= 1'b0;
            in_ack <= 1'b1;
          end else if (scl_rise && in_ack && sda_s2) begin
            // host declined another byte
            st <= lbr_pkg::LBR_IDLE;
            in_ack <= 1'b0;
          end else if (ack_done) begin
            in_ack <= 1'b0;
            sda_oe <= !rd_value[7];
            rd_shift <= {rd_value[6:0], 1'b1};
            bit_cnt <= 4'h1;
          end
        end
        default: begin
          st <= lbr_pkg::LBR_IDLE;
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // open drain: only ever pulls low
  assign sda_out = 1'b0;

  // register writes; only the documented field bits are stored
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      gen_purpose <= lbr_pkg::GEN_PURPOSE_RST[6:0];
      primary_group_brightness <= lbr_pkg::PRIMARY_GROUP_BRIGHTNESS_RST[4:0];
      secondary_group_brightness <= lbr_pkg::SECONDARY_GROUP_BRIGHTNESS_RST[2:0];
      indicator_brightness <= lbr_pkg::INDICATOR_BRIGHTNESS_RST[2:0];
      ramp_step_time <= lbr_pkg::RAMP_STEP_TIME_RST[1:0];
    end else if (wr_fire) begin
      if (sel_gp) begin
        gen_purpose <= shift[6:0];
      end
      if (sel_ramp) begin
        ramp_step_time <= shift[1:0];
      end
      if (sel_pri) begin
        primary_group_brightness <= shift[4:0];
      end
      if (sel_sec) begin
        secondary_group_brightness <= shift[2:0];
      end
      if (sel_ind) begin
        indicator_brightness <= shift[2:0];
      end
    end
  end

  // primary group ramp, target taken live from the brightness register
  lbr_ramp #(
    .FAST_CYC(21'(lbr_pkg::STEP_FAST_CYC)),
    .MID_CYC(STEP_MID_CYC),
    .SLOW_CYC(STEP_SLOW_CYC),
    .SLOWEST_CYC(STEP_SLOWEST_CYC)
  ) u_ramp (
    .core_clk(core_clk),
    .rst(rst),
    .group_on(gen_purpose[lbr_pkg::GP_PRIMARY_ON]),
    .target(primary_group_brightness),
    .step_code(ramp_step_time),
    .level(ramp_level),
    .sinks_on(ramp_sinks_on)
  );

  // group gating; reassignable sinks follow their group unless shut
  wire sec_on = gen_purpose[lbr_pkg::GP_SECONDARY_ON];
  wire first_pri = gen_purpose[lbr_pkg::GP_FIRST_TO_PRIMARY];
  wire second_pri = gen_purpose[lbr_pkg::GP_SECOND_TO_PRIMARY];
  wire first_grp_on = first_pri ? ramp_sinks_on : sec_on;
  wire second_grp_on = second_pri ? ramp_sinks_on : sec_on;

  // outputs registered; the ramp level already is a flop, one more keeps
  // all sink controls aligned on the same edge
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      primary_sinks_level <= 5'h00;
      primary_sinks_on <= 1'b0;
      secondary_sinks_level <= 3'h0;
      secondary_sinks_on <= 1'b0;
      indicator_sink_level <= 3'h0;
      indicator_sink_on <= 1'b0;
      flex_sink_first_on <= 1'b0;
      flex_sink_first_in_primary <= 1'b0;
      flex_sink_second_on <= 1'b0;
      flex_sink_second_in_primary <= 1'b0;
    end else begin
      primary_sinks_level <= ramp_level;
      primary_sinks_on <= ramp_sinks_on;
      secondary_sinks_level <= secondary_group_brightness;
      secondary_sinks_on <= sec_on;
      indicator_sink_level <= indicator_brightness;
      indicator_sink_on <= gen_purpose[lbr_pkg::GP_INDICATOR_ON];
      flex_sink_first_on <= first_grp_on && !gen_purpose[lbr_pkg::GP_SHUT_FIVE_THREE];
      flex_sink_first_in_primary <= first_pri;
      flex_sink_second_on <= second_grp_on && !gen_purpose[lbr_pkg::GP_SHUT_SIX_TWO];
      flex_sink_second_in_primary <= second_pri;
    end
  end

endmodule : lbr_ctrl

// [lbr_ctrl_properties.sv]
// concurrent checks on the led brightness controller ports
// assumes one core_clk domain and the asynchronous active high rst
`timescale 1ns/1ps

module lbr_ctrl_properties #(
  parameter logic [20:0] STEP_MID_CYC = 21'(lbr_pkg::STEP_MID_CYC),
  parameter logic [20:0] STEP_SLOW_CYC = 21'(lbr_pkg::STEP_SLOW_CYC),
  parameter logic [20:0] STEP_SLOWEST_CYC = 21'(lbr_pkg::STEP_SLOWEST_CYC)
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // serial port
  input wire logic scl,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  // sink outputs
  input wire logic [4:0] primary_sinks_level,
  input wire logic primary_sinks_on,
  input wire logic [2:0] secondary_sinks_level,
  input wire logic secondary_sinks_on,
  input wire logic [2:0] indicator_sink_level,
  input wire logic indicator_sink_on,
  input wire logic flex_sink_first_on,
  input wire logic flex_sink_first_in_primary,
  input wire logic flex_sink_second_on,
  input wire logic flex_sink_second_in_primary
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // open drain: the data output may only ever pull low
  property p_drive_low;
    sda_out == 1'b0;
  endproperty
  a_drive_low: assert property (p_drive_low) else $error("sda output not low");

  // ramp moves one code at a time, never jumps
  property p_one_step;
    $changed(primary_sinks_level) |-> (primary_sinks_level == $past(primary_sinks_level) + 5'h01)
      || (primary_sinks_level == $past(primary_sinks_level) - 5'h01);
  endproperty
  a_one_step: assert property (p_one_step) else $error("ramp jumped");

  // every dwell in simulation is far above eight cycles
  property p_dwell;
    $changed(primary_sinks_level) |=> $stable(primary_sinks_level) [*8];
  endproperty
  a_dwell: assert property (p_dwell) else $error("ramp step too short");

  property p_off_zero;
    !primary_sinks_on |-> primary_sinks_level == 5'h00;
  endproperty
  a_off_zero: assert property (p_off_zero) else $error("primary off above zero");

  // data validity: the device never moves sda while scl is high
  property p_sda_hold;
    scl && $past(scl) |-> $stable(sda_oe);
  endproperty
  a_sda_hold: assert property (p_sda_hold) else $error("sda moved with scl high");

  // a secondary or indicator level only changes inside the acknowledge of its data byte
  property p_sec_ack;
    $changed(secondary_sinks_level) |-> sda_oe;
  endproperty
  a_sec_ack: assert property (p_sec_ack) else $error("secondary change outside ack");

  property p_ind_ack;
    $changed(indicator_sink_level) |-> sda_oe;
  endproperty
  a_ind_ack: assert property (p_ind_ack) else $error("indicator change outside ack");

  property p_reset;
    disable iff (1'b0) rst |-> !primary_sinks_on && !secondary_sinks_on && !indicator_sink_on
      && !sda_oe && primary_sinks_level == 5'h00;
  endproperty
  a_reset: assert property (p_reset) else $error("outputs active in reset");

  c_ramp_top: cover property (primary_sinks_level == 5'h02);
  c_ramp_off: cover property ($fell(primary_sinks_on));
  c_ack: cover property ($rose(sda_oe));
endmodule : lbr_ctrl_properties

bind lbr_ctrl lbr_ctrl_properties #(
  .STEP_MID_CYC(STEP_MID_CYC),
  .STEP_SLOW_CYC(STEP_SLOW_CYC),
  .STEP_SLOWEST_CYC(STEP_SLOWEST_CYC)
) lbr_ctrl_properties_inst (
  .core_clk, .rst, .scl, .sda_in, .sda_out, .sda_oe,
  .primary_sinks_level, .primary_sinks_on, .secondary_sinks_level, .secondary_sinks_on,
  .indicator_sink_level, .indicator_sink_on, .flex_sink_first_on, .flex_sink_first_in_primary,
  .flex_sink_second_on, .flex_sink_second_in_primary
);

// [lbr_host.sv]
// two-wire host model that programs the brightness registers
// assumes a pulled-up sda line; phases of 6 core_clk keep edges visible
`timescale 1ns/1ps

module lbr_host (
  // clock
  input wire logic core_clk,
  // serial pins
  input wire logic sda_oe,
  output logic scl,
  output logic sda_in
);
  logic pull_low;

  // wired-and line with pull-up, fed back to the device
  assign sda_in = ~(pull_low | sda_oe);

  initial begin
    scl = 1'b1;
    pull_low = 1'b0;
  end

  task tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick

  // sda moves only while scl is low
  task put_bit(input logic b);
    pull_low <= ~b;
    tick(3);
    scl <= 1'b1;
    tick(6);
    scl <= 1'b0;
    tick(3);
  endtask : put_bit

  task get_bit(output logic b);
    pull_low <= 1'b0;
    tick(3);
    scl <= 1'b1;
    tick(3);
    b = sda_in;
    tick(3);
    scl <= 1'b0;
    tick(3);
  endtask : get_bit

  task start;
    pull_low <= 1'b0;
    tick(3);
    scl <= 1'b1;
    tick(6);
    pull_low <= 1'b1;
    tick(6);
    scl <= 1'b0;
    tick(3);
  endtask : start

  task stop;
    pull_low <= 1'b1;
    tick(3);
    scl <= 1'b1;
    tick(6);
    pull_low <= 1'b0;
    tick(6);
  endtask : stop

  // msb first, then the acknowledge slot
  task put_byte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i]);
    end
    get_bit(b);
    ack = ~b;
  endtask : put_byte

  // a write frame: address, pointer, one data byte
  task xfer_wr(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] d, output logic ok);
    logic a0;
    logic a1;
    logic a2;
    start();
    put_byte({dev, 1'b0}, a0);
    put_byte(ptr, a1);
    put_byte(d, a2);
    stop();
    ok = a0 & a1 & a2;
  endtask : xfer_wr

  // pointer write, repeated start, one byte read and nack
  task xfer_rd(input logic [7:0] ptr, output logic [7:0] d);
    logic a;
    start();
    put_byte({lbr_pkg::DEV_ADDR, 1'b0}, a);
    put_byte(ptr, a);
    start();
    put_byte({lbr_pkg::DEV_ADDR, 1'b1}, a);
    for (int i = 7; i >= 0; i--) begin
      get_bit(d[i]);
    end
    put_bit(1'b1);
    stop();
  endtask : xfer_rd
endmodule : lbr_host

// [lbr_tb.sv]
// self-checking bench for the led brightness controller
// assumes the host model drives the serial pins; mid, slow and slowest dwell counts are shortened
`timescale 1ns/1ps

`define LBR_CHK(a, b) begin \
  tests_run++; \
  if ((a) !== (b)) begin \
    error_cnt++; \
    $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); \
  end \
end

module testbench;
  localparam logic [20:0] MID = 21'h64;
  localparam logic [20:0] SLOW = 21'h96;
  localparam logic [20:0] SLOWEST = 21'hC8;

  logic core_clk;
  logic rst;
  logic scl;
  logic sda_in;
  logic sda_out;
  logic sda_oe;
  logic [4:0] primary_sinks_level;
  logic primary_sinks_on;
  logic [2:0] secondary_sinks_level;
  logic secondary_sinks_on;
  logic [2:0] indicator_sink_level;
  logic indicator_sink_on;
  logic flex_first_on;
  logic flex_first_prim;
  logic flex_second_on;
  logic flex_second_prim;
  logic ok;
  logic [7:0] d;
  int error_cnt = 0;
  int tests_run = 0;
  // code 00 dwell is fixed in the design, not a parameter
  int dw[4] = '{lbr_pkg::STEP_FAST_CYC, int'(MID), int'(SLOW), int'(SLOWEST)};
  logic [7:0] ra[6] = '{8'h10, 8'h20, 8'hA0, 8'hB0, 8'hC0, 8'h60};
  logic [7:0] rv[6] = '{8'h00, 8'hF0, 8'hE0, 8'hF8, 8'hF8, 8'h00};

  lbr_ctrl #(.STEP_MID_CYC(MID), .STEP_SLOW_CYC(SLOW), .STEP_SLOWEST_CYC(SLOWEST)) lbr_ctrl_inst (
    .core_clk(core_clk), .rst(rst), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .primary_sinks_level(primary_sinks_level),
    .primary_sinks_on(primary_sinks_on), .secondary_sinks_level(secondary_sinks_level),
    .secondary_sinks_on(secondary_sinks_on), .indicator_sink_level(indicator_sink_level),
    .indicator_sink_on(indicator_sink_on), .flex_sink_first_on(flex_first_on),
    .flex_sink_first_in_primary(flex_first_prim), .flex_sink_second_on(flex_second_on),
    .flex_sink_second_in_primary(flex_second_prim)
  );

  lbr_host lbr_host_inst (.core_clk(core_clk), .sda_oe(sda_oe), .scl(scl), .sda_in(sda_in));

  // 50 ns period
  initial core_clk = 1'b0;
  always #25 core_clk = ~core_clk;

  task tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick

  task wr(input logic [7:0] a, input logic [7:0] v);
    lbr_host_inst.xfer_wr(lbr_pkg::DEV_ADDR, a, v, ok);
    `LBR_CHK(ok, 1'b1)
  endtask : wr

  task stop_test;
    if (error_cnt == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test

  // watchdog well above the expected ~25k cycles
  initial begin
    tick(60000);
    error_cnt++;
    stop_test();
  end

  initial begin
    // raised at 1 ns so the async reset edge is seen whatever order processes start in
    rst = 1'b0;
    #1 rst = 1'b1;
    tick(2);
    rst <= 1'b0;
    tick(5);
    for (int i = 0; i < 6; i++) begin
      lbr_host_inst.xfer_rd(ra[i], d);
      `LBR_CHK(d, rv[i])
    end
    // wrong device address must be ignored
    lbr_host_inst.xfer_wr(7'h37, 8'hB0, 8'h01, ok);
    `LBR_CHK(ok, 1'b0)
    wr(8'hB0, 8'hFF);
    wr(8'hC0, 8'h05);
    wr(8'h10, 8'h06);
    tick(10);
    `LBR_CHK({secondary_sinks_on, secondary_sinks_level}, 4'hF)
    `LBR_CHK({indicator_sink_on, indicator_sink_level}, 4'hD)
    `LBR_CHK({flex_first_on, flex_first_prim, flex_second_on, flex_second_prim}, 4'hA)
    lbr_host_inst.xfer_rd(8'hB0, d);
    `LBR_CHK(d, 8'hFF)
    wr(8'h10, 8'h66);
    tick(10);
    `LBR_CHK({flex_first_on, flex_second_on}, 2'h0)
    wr(8'hA0, 8'hFF);
    lbr_host_inst.xfer_rd(8'hA0, d);
    `LBR_CHK(d, 8'hFF)
    wr(8'hA0, 8'h02);
    // every step code: ramp up to 2, then back down to off
    for (int c = 0; c < 4; c++) begin
      wr(8'h20, 8'(c));
      lbr_host_inst.xfer_rd(8'h20, d);
      `LBR_CHK(d, 8'hF0 | 8'(c))
      wr(8'h10, 8'h01);
      tick(dw[c] * 3 / 2);
      `LBR_CHK(primary_sinks_level, 5'h01)
      tick(dw[c]);
      `LBR_CHK({primary_sinks_on, primary_sinks_level}, 6'h22)
      wr(8'h10, 8'h00);
      tick(dw[c] * 3 / 2);
      `LBR_CHK(primary_sinks_level, 5'h01)
      tick(dw[c]);
      `LBR_CHK({primary_sinks_on, primary_sinks_level}, 6'h00)
    end
    // both flex sinks moved to the primary group, first one shut
    wr(8'h10, 8'h18);
    tick(10);
    `LBR_CHK({flex_first_on, flex_first_prim, flex_second_on, flex_second_prim}, 4'h5)
    wr(8'h10, 8'h39);
    tick(10);
    `LBR_CHK({flex_first_on, flex_first_prim, flex_second_on, flex_second_prim}, 4'h7)
    `LBR_CHK({primary_sinks_on, secondary_sinks_on}, 2'h2)
    stop_test();
  end
endmodule : testbench
